// File: shared/adc_pkg.sv
package adc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses on the peripheral bus).
  localparam logic [7:0] RESULT_OFS = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h20;
  localparam logic [7:0] CHAN_EN_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h30;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h34;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int RES_LSB = 0;
  localparam int RES_MSB = 9;
  localparam int RES_OVERRUN = 16;
  localparam int RES_VALID = 17;
  localparam int CTL_POWER = 0;
  localparam int CTL_IRQ_EN = 1;
  localparam int CTL_SRC_LSB = 4;
  localparam int CTL_SRC_MSB = 5;
  localparam int CTL_EDGE = 6;
  localparam int CTL_TRIG_EN = 8;
  localparam int CTL_START = 11;
  localparam int STS_END = 0;
  localparam int STS_OVERRUN = 1;
  localparam int STS_W = 2;
  localparam int CHAN_N = 8;
  localparam int CHAN_W = 3;
  localparam int RES_W = 10;

  ////////////////////////////////////////////////////////////////////////////////
  // Codes and reset values.
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_PWM = 2'h3;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [STS_W-1:0] MASK_RESET = 2'h3;
  localparam logic [CHAN_N-1:0] CHAN_EN_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS = 20;
  localparam int PIN_STABLE_NS = 80;
  localparam int PIN_STABLE_CYC = (PIN_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic start;
    logic trig_en;
    logic edge_rise;
    logic [1:0] src;
    logic irq_en;
    logic power;
  } control_s;

  typedef struct packed {
    logic valid;
    logic overrun;
    logic [RES_W-1:0] value;
  } result_s;

  typedef enum logic {CONV_IDLE, CONV_BUSY} conv_state_e;

endpackage

// File: core/start_pin_filter.sv
`timescale 1ns/1ns
module start_pin_filter (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw pin level
  input wire logic pin_in,
  // Qualified edges, one cycle each
  output logic rise_q,
  output logic fall_q
);

  logic [7:0] cnt_q;
  logic level_q;
  logic seeded_q;
  logic qualify;
  logic seed_done;
  logic restart;

  localparam logic [7:0] STABLE_LAST = 8'(adc_pkg::PIN_STABLE_CYC - 1);

  // Before seeding the counter times how long the pin has matched level_q; afterwards how long it has differed.
  assign qualify = seeded_q && (pin_in != level_q) && (cnt_q == STABLE_LAST);
  assign seed_done = !seeded_q && (pin_in == level_q) && (cnt_q == STABLE_LAST);
  assign restart = ((pin_in == level_q) == seeded_q) || qualify || seed_done;

  // A level only counts once it has held for the full minimum; once seeded, shorter pulses never move level_q.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
    end else if (restart) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // The level after reset only seeds the filter, so whatever the pin idles at is never taken as an edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
      seeded_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= qualify && pin_in;
      fall_q <= qualify && !pin_in;
      if (qualify || !seeded_q) begin
        level_q <= pin_in;
      end
      if (seed_done) begin
        seeded_q <= 1'b1;
      end
    end
  end

endmodule

// File: core/adc_control_data_regs.sv
`timescale 1ns/1ns
module adc_control_data_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // Trigger inputs
  input wire logic external_start_pin,
  input wire logic pwm_trigger,
  // Analog converter
  input wire logic conv_done,
  input wire logic [9:0] conv_data,
  output logic converter_power_q,
  output logic conv_run_q,
  output logic [2:0] conv_channel_q,
  // Interrupt
  output logic irq_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic [adc_pkg::CHAN_W-1:0] lowest_channel(input logic [adc_pkg::CHAN_N-1:0] en);
    logic [adc_pkg::CHAN_W-1:0] pick;
    pick = '0;
    for (int i = adc_pkg::CHAN_N - 1; i >= 0; i--) begin
      if (en[i]) begin
        pick = adc_pkg::CHAN_W'(i);
      end
    end
    lowest_channel = pick;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = hit(addr, adc_pkg::RESULT_OFS) || hit(addr, adc_pkg::CONTROL_OFS) ||
             hit(addr, adc_pkg::CHAN_EN_OFS) || hit(addr, adc_pkg::STATUS_OFS) ||
             hit(addr, adc_pkg::IRQ_MASK_OFS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  adc_pkg::control_s ctrl_q;
  adc_pkg::result_s result_q;
  adc_pkg::conv_state_e state_q;
  logic [adc_pkg::CHAN_N-1:0] chan_en_q;
  logic [adc_pkg::STS_W-1:0] status_q;
  logic [adc_pkg::STS_W-1:0] mask_q;
  logic pin_rise;
  logic pin_fall;

  logic take;
  logic xfer;
  logic wr;
  logic rd_result;
  logic wr_ctrl;
  logic pin_edge;
  logic hw_trig;
  logic completion;
  logic overrun_now;
  logic [adc_pkg::STS_W-1:0] sts_events;
  logic [adc_pkg::STS_W-1:0] irq_gate;
  logic [31:0] read_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // Every access waits one cycle; the register read and its side effects happen on the first access edge.
  assign take = psel && penable && !pready_q;
  assign xfer = psel && penable && pready_q;
  assign wr = xfer && pwrite && mapped(paddr);
  assign wr_ctrl = wr && hit(paddr, adc_pkg::CONTROL_OFS);
  // The clear-on-read acts on the edge that samples prdata, so a result landing later is never lost.
  assign rd_result = take && !pwrite && hit(paddr, adc_pkg::RESULT_OFS);

  always_comb begin
    read_word = adc_pkg::ZERO_WORD;
    if (hit(paddr, adc_pkg::RESULT_OFS)) begin
      read_word[adc_pkg::RES_MSB:adc_pkg::RES_LSB] = result_q.value;
      read_word[adc_pkg::RES_VALID] = result_q.valid;
      read_word[adc_pkg::RES_OVERRUN] = result_q.overrun;
    end else if (hit(paddr, adc_pkg::CONTROL_OFS)) begin
      read_word[adc_pkg::CTL_POWER] = ctrl_q.power;
      read_word[adc_pkg::CTL_IRQ_EN] = ctrl_q.irq_en;
      read_word[adc_pkg::CTL_SRC_MSB:adc_pkg::CTL_SRC_LSB] = ctrl_q.src;
      read_word[adc_pkg::CTL_EDGE] = ctrl_q.edge_rise;
      read_word[adc_pkg::CTL_TRIG_EN] = ctrl_q.trig_en;
      read_word[adc_pkg::CTL_START] = ctrl_q.start;
    end else if (hit(paddr, adc_pkg::CHAN_EN_OFS)) begin
      read_word[adc_pkg::CHAN_N-1:0] = chan_en_q;
    end else if (hit(paddr, adc_pkg::STATUS_OFS)) begin
      read_word[adc_pkg::STS_W-1:0] = status_q;
    end else if (hit(paddr, adc_pkg::IRQ_MASK_OFS)) begin
      read_word[adc_pkg::STS_W-1:0] = mask_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= adc_pkg::ZERO_WORD;
    end else begin
      pready_q <= take;
      pslverr_q <= take && !mapped(paddr);
      if (take && !pwrite) begin
        prdata_q <= read_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Triggers.

  start_pin_filter u_pin (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(external_start_pin),
    .rise_q(pin_rise),
    .fall_q(pin_fall)
  );

  assign pin_edge = ctrl_q.edge_rise ? pin_rise : pin_fall;
  // Reserved source codes select nothing, so they can never start a conversion.
  assign hw_trig = ctrl_q.trig_en &&
                   (((ctrl_q.src == adc_pkg::SRC_PIN) && pin_edge) ||
                    ((ctrl_q.src == adc_pkg::SRC_PWM) && pwm_trigger));

  ////////////////////////////////////////////////////////////////////////////////
  // Control register.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.power <= pwdata[adc_pkg::CTL_POWER];
        ctrl_q.irq_en <= pwdata[adc_pkg::CTL_IRQ_EN];
        ctrl_q.src <= pwdata[adc_pkg::CTL_SRC_MSB:adc_pkg::CTL_SRC_LSB];
        ctrl_q.edge_rise <= pwdata[adc_pkg::CTL_EDGE];
        ctrl_q.trig_en <= pwdata[adc_pkg::CTL_TRIG_EN];
      end
      // A trigger in the same cycle as completion or a software clear wins and starts again.
      if (hw_trig) begin
        ctrl_q.start <= 1'b1;
      end else if (completion) begin
        ctrl_q.start <= 1'b0;
      end else if (wr_ctrl) begin
        ctrl_q.start <= pwdata[adc_pkg::CTL_START];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_en_q <= adc_pkg::CHAN_EN_RESET;
      mask_q <= adc_pkg::MASK_RESET;
    end else if (wr) begin
      if (hit(paddr, adc_pkg::CHAN_EN_OFS)) begin
        chan_en_q <= pwdata[adc_pkg::CHAN_N-1:0];
      end
      if (hit(paddr, adc_pkg::IRQ_MASK_OFS)) begin
        mask_q <= pwdata[adc_pkg::STS_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.

  assign completion = (state_q == adc_pkg::CONV_BUSY) && conv_done && ctrl_q.start && ctrl_q.power;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= adc_pkg::CONV_IDLE;
      conv_run_q <= 1'b0;
      conv_channel_q <= '0;
      converter_power_q <= 1'b0;
    end else begin
      converter_power_q <= ctrl_q.power;
      case (state_q)
        adc_pkg::CONV_IDLE: begin
          if (ctrl_q.start && ctrl_q.power) begin
            state_q <= adc_pkg::CONV_BUSY;
            conv_run_q <= 1'b1;
            conv_channel_q <= lowest_channel(chan_en_q);
          end
        end
        adc_pkg::CONV_BUSY: begin
          // Dropping start or power abandons the conversion with no result.
          if (!ctrl_q.start || !ctrl_q.power || completion) begin
            state_q <= adc_pkg::CONV_IDLE;
            conv_run_q <= 1'b0;
          end
        end
        default: begin
          state_q <= adc_pkg::CONV_IDLE;
          conv_run_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result register.

  assign overrun_now = completion && result_q.valid && !rd_result;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
    end else if (completion) begin
      result_q.value <= conv_data;
      result_q.valid <= 1'b1;
      result_q.overrun <= overrun_now;
    end else if (rd_result) begin
      result_q.valid <= 1'b0;
      result_q.overrun <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status and interrupt.

  assign sts_events[adc_pkg::STS_END] = completion;
  assign sts_events[adc_pkg::STS_OVERRUN] = overrun_now;

  // Write-one-to-clear; a new event in the clearing cycle keeps its bit set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else if (wr && hit(paddr, adc_pkg::STATUS_OFS)) begin
      status_q <= (status_q & ~pwdata[adc_pkg::STS_W-1:0]) | sts_events;
    end else begin
      status_q <= status_q | sts_events;
    end
  end

  assign irq_gate[adc_pkg::STS_END] = ctrl_q.irq_en;
  assign irq_gate[adc_pkg::STS_OVERRUN] = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q & irq_gate);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_result_load: assert property (completion |=> result_q.value == $past(conv_data) && result_q.valid)
    else $error("Result not loaded on completion.");
  a_valid_clear: assert property (rd_result && !completion |=> !result_q.valid && !result_q.overrun)
    else $error("Result flags not cleared by read.");
  a_overrun_set: assert property (completion && result_q.valid && !rd_result |=> result_q.overrun)
    else $error("Overrun not flagged.");
  a_start_done: assert property (completion && !hw_trig |=> !ctrl_q.start ##1 !conv_run_q)
    else $error("Start bit not cleared on completion.");
  a_abort_idle: assert property (conv_run_q && !ctrl_q.start |=> !conv_run_q)
    else $error("Conversion not abandoned.");
  a_trig_gate: assert property (!ctrl_q.trig_en && !ctrl_q.start && !wr_ctrl |=> !ctrl_q.start)
    else $error("Start set with triggers disabled.");
  a_pin_edge: assert property (ctrl_q.trig_en && ctrl_q.src == adc_pkg::SRC_PIN && !ctrl_q.edge_rise
                               && pin_fall |=> ctrl_q.start)
    else $error("Falling pin edge did not start.");
  a_pwm_start: assert property (ctrl_q.trig_en && ctrl_q.src == adc_pkg::SRC_PWM && pwm_trigger
                                |=> ctrl_q.start)
    else $error("PWM trigger did not start.");
  a_irq_gate: assert property (!ctrl_q.irq_en && !status_q[adc_pkg::STS_OVERRUN] |=> !irq_q)
    else $error("Interrupt without enable.");
  a_end_flag: assert property (completion |=> status_q[adc_pkg::STS_END])
    else $error("End flag not set.");
  a_power_run: assert property (conv_run_q |-> converter_power_q)
    else $error("Running while powered down.");
  a_lowest_chan: assert property ($rose(conv_run_q) |-> conv_channel_q == lowest_channel($past(chan_en_q)))
    else $error("Wrong channel selected.");
  a_resv_zero: assert property (pready_q && !pwrite |-> prdata_q[31:18] == 14'h0000)
    else $error("Reserved bits read nonzero.");
  a_unmapped_zero: assert property (take && !pwrite && !mapped(paddr) |=> prdata_q == adc_pkg::ZERO_WORD)
    else $error("Unmapped read returned data.");
  a_idle_stop: assert property (!ctrl_q.start |=> !conv_run_q)
    else $error("Converter running with start bit clear.");
  a_power_abort: assert property (!ctrl_q.power |=> !conv_run_q)
    else $error("Converter running while disabled.");
  a_pin_rise: assert property (ctrl_q.trig_en && ctrl_q.src == adc_pkg::SRC_PIN && ctrl_q.edge_rise
                               && pin_rise |=> ctrl_q.start)
    else $error("Rising pin edge did not start.");
  // Codes 01 and 10 of the source field select nothing, so they must never set the start bit.
  a_resv_source: assert property (ctrl_q.trig_en && ctrl_q.src != adc_pkg::SRC_PIN
                                  && ctrl_q.src != adc_pkg::SRC_PWM
                                  && !ctrl_q.start && !wr_ctrl |=> !ctrl_q.start)
    else $error("Reserved source started a conversion.");
  a_irq_level: assert property (ctrl_q.irq_en && status_q[adc_pkg::STS_END]
                                && mask_q[adc_pkg::STS_END] |=> irq_q)
    else $error("Enabled end flag did not interrupt.");
  a_overrun_flag: assert property (overrun_now |=> status_q[adc_pkg::STS_OVERRUN])
    else $error("Overrun event not recorded.");
  a_chan_hold: assert property (conv_run_q && $past(conv_run_q) |-> $stable(conv_channel_q))
    else $error("Channel changed mid-conversion.");
  // A qualified edge needs the new level on each of the four edges before it was reported.
  a_fall_qualify: assert property (pin_fall |-> !$past(external_start_pin)
                                   && !$past(external_start_pin, 2) && !$past(external_start_pin, 3)
                                   && !$past(external_start_pin, 4))
    else $error("Short low pulse taken as an edge.");
  a_rise_qualify: assert property (pin_rise |-> $past(external_start_pin)
                                   && $past(external_start_pin, 2) && $past(external_start_pin, 3)
                                   && $past(external_start_pin, 4))
    else $error("Short high pulse taken as an edge.");

endmodule

// File: bench/adc_control_data_regs_tb.sv
`timescale 1ns/1ns
module adc_control_data_regs_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic external_start_pin = 1'b1;
  logic pwm_trigger = 1'b0;
  logic conv_done = 1'b0;
  logic [9:0] conv_data = 10'h000;
  logic converter_power_q;
  logic conv_run_q;
  logic [2:0] conv_channel_q;
  logic irq_q;
  int err_count = 0;
  int compares = 0;
  logic [31:0] rd;
  logic er;

  ////////////////////////////////////////////////////////////////////////////////
  adc_control_data_regs u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .external_start_pin(external_start_pin), .pwm_trigger(pwm_trigger), .conv_done(conv_done),
    .conv_data(conv_data), .converter_power_q(converter_power_q), .conv_run_q(conv_run_q),
    .conv_channel_q(conv_channel_q), .irq_q(irq_q)
  );

  always #10 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("Comparisons %0d, errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // The slave inserts one wait state; the wait itself is bounded only by the watchdog.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1);
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n), 32'h0000_0002, "access cycles");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, msg);
    chk({31'h0, er}, 32'h0000_0000, "slave error");
  endtask

  task automatic pwm_pulse;
    @(posedge pclk);
    pwm_trigger <= 1'b1;
    @(posedge pclk);
    pwm_trigger <= 1'b0;
  endtask

  task automatic wait_run;
    int n;
    n = 0;
    while (conv_run_q !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, conv_run_q}, 32'h0000_0001, "conversion running");
  endtask

  task automatic done(input logic [9:0] d);
    @(posedge pclk);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge pclk);
    conv_done <= 1'b0;
    cyc(3);
  endtask

  task automatic pin(input logic v, input int n);
    @(posedge pclk);
    external_start_pin <= v;
    cyc(n);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(adc_pkg::RESULT_OFS, 32'h0000_0000, "result reset");
    rdchk(adc_pkg::CONTROL_OFS, 32'h0000_0000, "control reset");
    rdchk(adc_pkg::IRQ_MASK_OFS, 32'h0000_0003, "mask reset");
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped data");
  endtask

  task automatic t_software;
    wr(adc_pkg::CHAN_EN_OFS, 32'h0000_000C);
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0803);
    wait_run();
    chk({31'h0, converter_power_q}, 32'h0000_0001, "power on");
    chk({29'h0, conv_channel_q}, 32'h0000_0002, "lowest channel");
    done(10'h2A5);
    chk({31'h0, conv_run_q}, 32'h0000_0000, "idle after done");
    rdchk(adc_pkg::CONTROL_OFS, 32'h0000_0003, "start cleared");
    chk({31'h0, irq_q}, 32'h0000_0001, "irq raised");
    rdchk(adc_pkg::STATUS_OFS, 32'h0000_0001, "end flag");
    rdchk(adc_pkg::RESULT_OFS, 32'h0002_02A5, "result valid");
    rdchk(adc_pkg::RESULT_OFS, 32'h0000_02A5, "valid cleared");
    wr(adc_pkg::STATUS_OFS, 32'h0000_0003);
    cyc(2);
    chk({31'h0, irq_q}, 32'h0000_0000, "irq cleared");
  endtask

  task automatic t_overrun;
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0801);
    wait_run();
    done(10'h111);
    chk({31'h0, irq_q}, 32'h0000_0000, "irq disabled");
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0801);
    wait_run();
    done(10'h222);
    rdchk(adc_pkg::RESULT_OFS, 32'h0003_0222, "overrun set");
    rdchk(adc_pkg::RESULT_OFS, 32'h0000_0222, "overrun cleared");
    wr(adc_pkg::STATUS_OFS, 32'h0000_0003);
  endtask

  task automatic t_abort;
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0801);
    wait_run();
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0001);
    cyc(2);
    chk({31'h0, conv_run_q}, 32'h0000_0000, "aborted");
    done(10'h3FF);
    rdchk(adc_pkg::RESULT_OFS, 32'h0000_0222, "late done ignored");
  endtask

  task automatic t_power;
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0000);
    cyc(2);
    chk({31'h0, converter_power_q}, 32'h0000_0000, "power off");
    wr(adc_pkg::CONTROL_OFS, 32'hFFFF_F7FE);
    rdchk(adc_pkg::CONTROL_OFS, 32'h0000_0172, "reserved bits");
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0001);
  endtask

  task automatic t_pwm;
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0031);
    pwm_pulse();
    cyc(4);
    chk({31'h0, conv_run_q}, 32'h0000_0000, "trigger disabled");
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0111);
    pwm_pulse();
    cyc(4);
    chk({31'h0, conv_run_q}, 32'h0000_0000, "reserved source");
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0031);
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0131);
    pwm_pulse();
    wait_run();
    done(10'h155);
    rdchk(adc_pkg::RESULT_OFS, 32'h0002_0155, "pwm result");
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0001);
  endtask

  task automatic t_pin;
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0101);
    pin(1'b0, 1);
    pin(1'b1, 12);
    chk({31'h0, conv_run_q}, 32'h0000_0000, "short pulse ignored");
    pin(1'b0, 0);
    wait_run();
    done(10'h0F0);
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0001);
    wr(adc_pkg::CONTROL_OFS, 32'h0000_0141);
    pin(1'b1, 0);
    wait_run();
    done(10'h30F);
    rdchk(adc_pkg::RESULT_OFS, 32'h0003_030F, "pin results");
    wr(adc_pkg::STATUS_OFS, 32'h0000_0003);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_software();
    t_overrun();
    t_abort();
    t_power();
    t_pwm();
    t_pin();
    finish_test();
  end

  // The scenarios need well under two thousand cycles, so this only fires on a hang.
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    finish_test();
  end
endmodule
